/* File: hdl/gafm_pkg.sv */
/*
 * Constants for the general purpose pin function multiplexer: register
 * offsets, field positions, reset values and the pin function encodings.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package gafm_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int GAFM_NUM_PINS = 8;        // General purpose pins
    localparam int GAFM_NUM_REFS = 8;        // Reference monitors
    localparam int GAFM_NUM_CHANS = 4;       // Digital loop channels
    localparam int GAFM_SEL_W = 3;           // Source selector width

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] GAFM_OFS_CTRL = 8'h00;      // Global control
    localparam logic [7:0] GAFM_OFS_PIN_IN = 8'h04;    // Sampled pin levels
    localparam logic [7:0] GAFM_OFS_PIN_OUT = 8'h08;   // Output levels
    localparam logic [7:0] GAFM_OFS_STICKY = 8'h0C;    // Sticky alarm bits
    localparam logic [7:0] GAFM_OFS_STK_CLR = 8'h10;   // Sticky clear (W1C)
    localparam logic [7:0] GAFM_OFS_ALERT_EN = 8'h14;  // Alert enables
    localparam logic [7:0] GAFM_OFS_LIVE = 8'h18;      // Live alarm state
    localparam logic [7:0] GAFM_OFS_IRQ_STAT = 8'h1C;  // Interrupt status
    localparam logic [7:0] GAFM_OFS_IRQ_CLR = 8'h20;   // Interrupt clear
    localparam logic [7:0] GAFM_OFS_IRQ_EN = 8'h24;    // Interrupt enable
    localparam logic [7:0] GAFM_OFS_PIN_CFG0 = 8'h40;  // First pin config
    localparam logic [7:0] GAFM_PIN_CFG_STEP = 8'h04;  // Pin config stride

    // ************************************************************
    // Pin config field layout
    // ************************************************************
    localparam int GAFM_CFG_MODE_LSB = 0;    // Mode field [2:0]
    localparam int GAFM_CFG_SEL_LSB = 4;     // Source select [6:4]
    localparam int GAFM_CFG_INV_BIT = 8;     // Polarity invert
    localparam int GAFM_CFG_OEN_BIT = 9;     // Open drain select
    localparam logic [31:0] GAFM_CFG_MASK = 32'h0000_037F;

    // ************************************************************
    // Sticky bit layout: [3:0] lock change, [7:4] holdover change,
    // [8] system analog loop lock change
    // ************************************************************
    localparam int GAFM_STK_W = 9;
    localparam int GAFM_STK_HO_LSB = 4;
    localparam int GAFM_STK_SYS_BIT = 8;

    // Interrupt events: sticky set, any pin input change
    localparam int GAFM_IRQ_W = 2;
    localparam int GAFM_IRQ_STK_BIT = 0;
    localparam int GAFM_IRQ_PIN_BIT = 1;

    // Reset values
    localparam logic [31:0] GAFM_CFG_RESET = 32'h0000_0000;
    localparam logic GAFM_CTRL_RESET = 1'b0;

    // Pin functions
    typedef enum logic [2:0] {
        GAFM_MODE_INPUT = 3'h0,
        GAFM_MODE_OUTPUT = 3'h1,
        GAFM_MODE_LOS = 3'h2,
        GAFM_MODE_LOL_LIVE = 3'h3,
        GAFM_MODE_LOL_STK = 3'h4,
        GAFM_MODE_HO_LIVE = 3'h5,
        GAFM_MODE_HO_STK = 3'h6,
        GAFM_MODE_ALERT = 3'h7
    } gafm_mode_type;

endpackage

/* File: hdl/gafm_sticky.sv */
/*
 * Change detector with sticky flags: each flag is set on any edge of its
 * live input and cleared by a one-cycle clear pulse; set wins over clear.
 * Assumes the live inputs are already on aclk.
 */
`timescale 1ns/1ns

module gafm_sticky #(
    parameter int WIDTH = 9
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arm,
    input wire logic [WIDTH-1:0] live,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] sticky_q,
    output logic [WIDTH-1:0] changed
);

    // Previous live state for edge detection
    logic [WIDTH-1:0] live_prev_q;

    initial begin
        if (WIDTH < 1) begin
            $error("gafm_sticky: WIDTH must be at least 1");
        end
    end

    // Change seen this cycle, only once armed
    assign changed = arm ? (live ^ live_prev_q) : '0;

    // ************************************************************
    // Previous value tracker
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            live_prev_q <= '0;
        end else begin
            live_prev_q <= live;
        end
    end

    // ************************************************************
    // Sticky flags
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= (sticky_q & ~clear) | changed;
        end
    end

endmodule

/* File: hdl/gafm_sync.sv */
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no bus coherence is promised.
 */
`timescale 1ns/1ns

module gafm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("gafm_sync: WIDTH must be at least 1");
        end
    end

    // ************************************************************
    // Two stage capture
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: hdl/gafm_top.sv */
/*
 * General purpose pin function multiplexer. Each pin is an input, a
 * register-driven output, or an alarm output fed by loss-of-signal, lock
 * and holdover status, live or sticky, with optional inversion.
 * Assumes status inputs are on aclk; pin inputs are asynchronous; the
 * reset sequence end is flagged by an on-chip level on aclk.
 */
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns

// Behaviour
// RULE_01 - Pin functions apply only after reset sequence
// RULE_02 - Input mode level readable in status register
// RULE_03 - Default function is general purpose input
// RULE_04 - Output mode drives register-held level
// RULE_05 - Per-pin config; same config, same output
// RULE_06 - Loss-of-signal active high, optional inversion
// RULE_07 - Loss-of-signal follows selected reference monitor
// RULE_08 - Loss-of-signal is live, never latched
// RULE_09 - Live loss-of-lock high while unlocked
// RULE_10 - Sticky loss-of-lock set on lock change
// RULE_11 - Live holdover high while in holdover
// RULE_12 - Sticky holdover set on holdover change
// RULE_13 - Sticky indications invertible to active low
// RULE_14 - Sticky holds until clear register written
// RULE_15 - Alert ORs enabled sticky bits, invertible
// RULE_16 - Sticky set on assertion and negation
// RULE_17 - Pin inputs pass two-stage synchroniser
module gafm_top
    import gafm_pkg::*;
#(
    parameter int NUM_PINS = GAFM_NUM_PINS
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // On-chip status
    input wire logic reset_seq_done,
    input wire logic [GAFM_NUM_REFS-1:0] ref_los_alarm,
    input wire logic [GAFM_NUM_CHANS-1:0] chan_locked,
    input wire logic [GAFM_NUM_CHANS-1:0] chan_holdover,
    input wire logic system_analog_loop_locked,
    // Pins
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    output logic irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [31:0] pin_cfg_q [NUM_PINS];       // Per-pin configuration
    logic [NUM_PINS-1:0] out_level_q;        // Output mode levels
    logic [GAFM_STK_W-1:0] alert_en_q;       // Alert enables
    logic [GAFM_IRQ_W-1:0] irq_stat_q;       // Interrupt status
    logic [GAFM_IRQ_W-1:0] irq_en_q;         // Interrupt enable
    logic active_q;                          // Reset sequence complete
    logic [NUM_PINS-1:0] pin_sync;           // Synchronised pins
    logic [NUM_PINS-1:0] pin_prev_q;         // For change events
    logic [GAFM_STK_W-1:0] live_vec;         // Live change sources
    logic [GAFM_STK_W-1:0] sticky;           // Sticky flags
    logic [GAFM_STK_W-1:0] stk_changed;      // Sticky set pulses
    logic [GAFM_STK_W-1:0] stk_clear;        // Clear pulses
    logic [GAFM_NUM_CHANS-1:0] unlocked;     // Live loss of lock
    logic alert_any;                         // Aggregated alert
    logic [NUM_PINS-1:0] pin_val_d;          // Next pin level
    logic [NUM_PINS-1:0] pin_drv_d;          // Next drive enable
    logic [NUM_PINS-1:0] od_d;               // Open drain per pin
    logic aw_hold_q;                         // Write address held
    logic w_hold_q;                          // Write data held
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;                             // Both halves present

    initial begin
        if (NUM_PINS < 1 || NUM_PINS > 16) begin
            $error("gafm_top: NUM_PINS must be 1 to 16");
        end
    end

    // Byte-lane merge of write data over an old value
    function automatic logic [31:0] merge_wr(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Pin config index for an address, NUM_PINS when not a config word
    function automatic int cfg_index(input logic [7:0] addr);
        int idx;
        idx = NUM_PINS;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (addr == 8'(GAFM_OFS_PIN_CFG0 + p * GAFM_PIN_CFG_STEP)) begin
                idx = p;
            end
        end
        return idx;
    endfunction

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    gafm_sync #(
        .WIDTH(NUM_PINS)
    ) gafm_sync_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_sync)                  // [RULE_17]
    );

    // ************************************************************
    // Alarm sources and sticky flags
    // ************************************************************
    assign unlocked = ~(chan_locked & {GAFM_NUM_CHANS{system_analog_loop_locked}});
    assign live_vec = {~system_analog_loop_locked, chan_holdover, unlocked};

    gafm_sticky #(
        .WIDTH(GAFM_STK_W)
    ) gafm_sticky_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(active_q),
        .live(live_vec),
        .clear(stk_clear),
        .sticky_q(sticky),                   // [RULE_16]
        .changed(stk_changed)
    );

    // Aggregated alert from enabled sticky flags
    assign alert_any = |(sticky & alert_en_q); // [RULE_15]

    // ************************************************************
    // Reset sequence tracker
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_q <= GAFM_CTRL_RESET;
        end else if (reset_seq_done) begin
            active_q <= 1'b1;                // [RULE_01]
        end
    end

    // ************************************************************
    // Pin function multiplexer
    // ************************************************************
    always_comb begin
        pin_val_d = '0;
        pin_drv_d = '0;
        od_d = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            // Same fields give the same level on every pin, except in output mode where out_level_q[p] is per pin
            automatic logic [GAFM_SEL_W-1:0] sel; // [RULE_05]
            automatic logic inv;
            automatic gafm_mode_type mode;
            sel = pin_cfg_q[p][GAFM_CFG_SEL_LSB +: GAFM_SEL_W];
            inv = pin_cfg_q[p][GAFM_CFG_INV_BIT];
            mode = gafm_mode_type'(pin_cfg_q[p][GAFM_CFG_MODE_LSB +: 3]);
            od_d[p] = pin_cfg_q[p][GAFM_CFG_OEN_BIT];
            pin_drv_d[p] = active_q;         // [RULE_01]
            case (mode)
                GAFM_MODE_INPUT: begin
                    pin_drv_d[p] = 1'b0;     // [RULE_03]
                end
                GAFM_MODE_OUTPUT: begin
                    pin_val_d[p] = out_level_q[p]; // [RULE_04]
                end
                GAFM_MODE_LOS: begin
                    // Live monitor alarm, no latch
                    pin_val_d[p] = ref_los_alarm[sel] ^ inv; // [RULE_06] [RULE_07] [RULE_08]
                end
                GAFM_MODE_LOL_LIVE: begin
                    if (sel[2]) begin
                        pin_val_d[p] = ~system_analog_loop_locked ^ inv; // [RULE_09]
                    end else begin
                        pin_val_d[p] = unlocked[sel[1:0]] ^ inv; // [RULE_09]
                    end
                end
                GAFM_MODE_LOL_STK: begin
                    if (sel[2]) begin
                        pin_val_d[p] = sticky[GAFM_STK_SYS_BIT] ^ inv; // [RULE_10] [RULE_13]
                    end else begin
                        pin_val_d[p] = sticky[sel[1:0]] ^ inv; // [RULE_10] [RULE_13] [RULE_14]
                    end
                end
                GAFM_MODE_HO_LIVE: begin
                    pin_val_d[p] = chan_holdover[sel[1:0]] ^ inv; // [RULE_11]
                end
                GAFM_MODE_HO_STK: begin
                    pin_val_d[p] = sticky[GAFM_STK_HO_LSB + 32'(sel[1:0])] ^ inv; // [RULE_12] [RULE_13]
                end
                default: begin
                    pin_val_d[p] = alert_any ^ inv; // [RULE_15]
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drivers: open drain only ever pulls low
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
            pin_oe_n <= '1;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                pin_out[p] <= od_d[p] ? 1'b0 : pin_val_d[p];
                pin_oe_n[p] <= ~(pin_drv_d[p] & (~od_d[p] | ~pin_val_d[p]));
            end
        end
    end

    // ************************************************************
    // AXI4-Lite write channel capture
    // ************************************************************
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign wr_go = aw_hold_q && w_hold_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response, OKAY or DECERR for unmapped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == GAFM_OFS_PIN_OUT || awaddr_q == GAFM_OFS_STK_CLR ||
                    awaddr_q == GAFM_OFS_ALERT_EN || awaddr_q == GAFM_OFS_IRQ_CLR ||
                    awaddr_q == GAFM_OFS_IRQ_EN || cfg_index(awaddr_q) < NUM_PINS ||
                    awaddr_q == GAFM_OFS_CTRL || awaddr_q == GAFM_OFS_PIN_IN ||
                    awaddr_q == GAFM_OFS_STICKY || awaddr_q == GAFM_OFS_LIVE ||
                    awaddr_q == GAFM_OFS_IRQ_STAT) begin
                s_axi_bresp <= 2'h0;
            end else begin
                s_axi_bresp <= 2'h3;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Writable registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < NUM_PINS; p++) begin
                pin_cfg_q[p] <= GAFM_CFG_RESET;  // [RULE_03]
            end
            out_level_q <= '0;
            alert_en_q <= '0;
            irq_en_q <= '0;
        end else if (wr_go) begin
            if (awaddr_q == GAFM_OFS_PIN_OUT) begin
                out_level_q <= NUM_PINS'(merge_wr(32'(out_level_q), wdata_q, wstrb_q));
            end else if (awaddr_q == GAFM_OFS_ALERT_EN) begin
                alert_en_q <= GAFM_STK_W'(merge_wr(32'(alert_en_q), wdata_q, wstrb_q));
            end else if (awaddr_q == GAFM_OFS_IRQ_EN) begin
                irq_en_q <= GAFM_IRQ_W'(merge_wr(32'(irq_en_q), wdata_q, wstrb_q));
            end else if (cfg_index(awaddr_q) < NUM_PINS) begin
                pin_cfg_q[cfg_index(awaddr_q)] <= merge_wr(pin_cfg_q[cfg_index(awaddr_q)],
                    wdata_q, wstrb_q) & GAFM_CFG_MASK;
            end
        end
    end

    // Sticky clear pulse from a write of ones
    always_comb begin
        stk_clear = '0;
        if (wr_go && awaddr_q == GAFM_OFS_STK_CLR) begin
            stk_clear = GAFM_STK_W'(merge_wr(32'h0, wdata_q, wstrb_q)); // [RULE_14]
        end
    end

    // ************************************************************
    // Interrupt status: set wins over clear
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_sync;
            if (wr_go && awaddr_q == GAFM_OFS_IRQ_CLR) begin
                irq_stat_q <= irq_stat_q & ~GAFM_IRQ_W'(merge_wr(32'h0, wdata_q, wstrb_q))
                    | {|(pin_sync ^ pin_prev_q), |stk_changed};
            end else begin
                irq_stat_q <= irq_stat_q | {|(pin_sync ^ pin_prev_q), |stk_changed};
            end
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (s_axi_araddr == GAFM_OFS_CTRL) begin
                s_axi_rdata <= 32'(active_q);
            end else if (s_axi_araddr == GAFM_OFS_PIN_IN) begin
                s_axi_rdata <= 32'(pin_sync);    // [RULE_02]
            end else if (s_axi_araddr == GAFM_OFS_PIN_OUT) begin
                s_axi_rdata <= 32'(out_level_q);
            end else if (s_axi_araddr == GAFM_OFS_STICKY) begin
                s_axi_rdata <= 32'(sticky);
            end else if (s_axi_araddr == GAFM_OFS_ALERT_EN) begin
                s_axi_rdata <= 32'(alert_en_q);
            end else if (s_axi_araddr == GAFM_OFS_LIVE) begin
                s_axi_rdata <= 32'(live_vec);
            end else if (s_axi_araddr == GAFM_OFS_IRQ_STAT) begin
                s_axi_rdata <= 32'(irq_stat_q);
            end else if (s_axi_araddr == GAFM_OFS_IRQ_EN) begin
                s_axi_rdata <= 32'(irq_en_q);
            end else if (cfg_index(s_axi_araddr) < NUM_PINS) begin
                s_axi_rdata <= pin_cfg_q[cfg_index(s_axi_araddr)];
            end else begin
                s_axi_rdata <= '0;           // Unmapped or write-only
                s_axi_rresp <= 2'h3;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* File: tb/gafm_board.sv */
/* Board side of the pins: each wire follows the block where it drives,
   the board level elsewhere. Assumes oe_n low means driving. */
`timescale 1ns/1ns
module gafm_board #(
    parameter int NUM_PINS = 8
) (
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_PINS-1:0] board_lvl,
    output logic [NUM_PINS-1:0] pin_wire
);
    // Resolve each wire from both parties
    assign pin_wire = (pin_oe_n & board_lvl) | (~pin_oe_n & pin_out);
endmodule

/* File: tb/gafm_chk_sva.sv */
/* Port checker for the pin function multiplexer.
   Assumes it is bound to gafm_top and sees only its ports. */
`timescale 1ns/1ns
module gafm_chk #(
    parameter int NUM_PINS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reset_seq_done,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic irq
);
    logic done_q; // Reset sequence seen
    logic cfg_q; // Some pin config written
    // Track sequence end and first config write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            cfg_q <= 1'b0;
        end else begin
            done_q <= done_q | reset_seq_done;
            cfg_q <= cfg_q | (s_axi_awvalid & s_axi_awready & (s_axi_awaddr >= 8'h40));
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_idle_a: assert property ($rose(aresetn) |-> &pin_oe_n && !irq)
        else $error("pins not idle after reset");
    pre_active_a: assert property (!done_q |=> &pin_oe_n)
        else $error("pin driven before sequence end");
    input_default_a: assert property (!cfg_q |-> &pin_oe_n)
        else $error("unconfigured pin driven");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
endmodule
bind gafm_top gafm_chk #(.NUM_PINS(NUM_PINS)) gafm_chk_inst (.*);

/* File: tb/test_gafm_top.sv */
/* Register level bench for the pin function multiplexer.
   Assumes the board model and the bound checker. */
`timescale 1ns/1ns
module test_gafm_top
    import gafm_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic reset_seq_done = 1'b0, system_analog_loop_locked = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ref_los_alarm = 8'h00, brd = 8'hA5;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, chan_locked = 4'hF, chan_holdover = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] pin_in, pin_out, pin_oe_n;
    int err_total = 0, tests_run = 0, cyc = 0;
    gafm_top gafm_top_inst (.*);
    gafm_board gafm_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_lvl(brd),
        .pin_wire(pin_in));
    initial forever #10 aclk = ~aclk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        @(posedge aclk) s_axi_bready <= 1'b1;
        @(posedge aclk) s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk) s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        rs = s_axi_rresp;
        chk(s_axi_rdata, e);
        @(posedge aclk) s_axi_rready <= 1'b1;
        @(posedge aclk) s_axi_rready <= 1'b0;
    endtask
    task automatic cfg(input int p, input logic [31:0] v);
        wr(GAFM_OFS_PIN_CFG0 + 8'(4 * p), v);
    endtask
    // Let pins settle, then look at a quiet point
    task automatic st;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask
    // Cut a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        cfg(0, 32'h1);
        wr(GAFM_OFS_PIN_OUT, 32'h1);
        st;
        chk(32'(pin_oe_n), 32'hFF);
        @(posedge aclk) reset_seq_done <= 1'b1;
        rd(GAFM_OFS_CTRL, 32'h1);
        rd(GAFM_OFS_PIN_IN, 32'hA5);
        rd(8'h80, 32'h0);
        chk(32'(rs), 32'h3);
        wr(8'h80, 32'h0);
        chk(32'(rs), 32'h3);
        st;
        chk(32'({pin_oe_n, pin_out[0]}), 32'h1FD);
        cfg(2, 32'h32);
        cfg(3, 32'h132);
        cfg(4, 32'h32);
        @(posedge aclk) ref_los_alarm <= 8'h08;
        st;
        chk(32'(pin_out[4:2]), 32'h5);
        @(posedge aclk) ref_los_alarm <= 8'h00;
        st;
        chk(32'(pin_out[4:2]), 32'h2);
        cfg(5, 32'h13);
        cfg(6, 32'h14);
        cfg(7, 32'h126);
        @(posedge aclk) chan_locked <= 4'hD;
        chan_holdover <= 4'h4;
        st;
        chk(32'(pin_out[7:5]), 32'h3);
        @(posedge aclk) chan_locked <= 4'hF;
        st;
        chk(32'(pin_out[7:5]), 32'h2);
        rd(GAFM_OFS_STICKY, 32'h42);
        cfg(5, 32'h25);
        wr(GAFM_OFS_STK_CLR, 32'h42);
        st;
        chk(32'(pin_out[7:5]), 32'h5);
        wr(GAFM_OFS_ALERT_EN, 32'h4);
        cfg(4, 32'h7);
        wr(GAFM_OFS_IRQ_EN, 32'h1);
        @(posedge aclk) chan_locked <= 4'hB;
        st;
        chk(32'({irq, pin_out[4]}), 32'h3);
        wr(GAFM_OFS_STK_CLR, 32'h4);
        wr(GAFM_OFS_IRQ_CLR, 32'h1);
        st;
        chk(32'({irq, pin_out[4]}), 32'h0);
        end_sim();
    end
endmodule
